// file: hdl/pbcc_pkg.sv
// How it works
// - static logic, clock may stop, no timeouts
// - each processor cycle takes three clock periods
// - instructions run two, three or four cycles
// - operation_request qualifies all other bus outputs
// - address and controls valid before request rises
// - memory read drives memory and read states
// - late acknowledge stalls the cycle indefinitely
// - request held until acknowledge is received
// - memory write same handshake, write state driven
// - one write_strobe_pulse per write sequence
// - input/output uses the same request/acknowledge exchange
// - handshake is level based, clock independent
package pbcc_pkg;
   // ==========================================================
   // bus widths and read buffer depth
   localparam int PBCC_ADDR_W = 15;
   localparam int PBCC_DATA_W = 8;
   localparam int PBCC_FIFO_DEPTH = 16;
   // ==========================================================
   // cycle structure
   localparam int PBCC_CLK_PER_CYC = 3;
   localparam logic [2:0] PBCC_MIN_CYC = 3'h2;
   localparam logic [2:0] PBCC_MAX_CYC = 3'h4;
   localparam logic [2:0] PBCC_CYC_STEP = 3'h1;
   // ==========================================================
   // select encodings
   localparam logic PBCC_SEL_MEM = 1'b1;
   localparam logic PBCC_SEL_IO = 1'b0;
   localparam logic PBCC_SEL_WRITE = 1'b1;
   localparam logic PBCC_SEL_READ = 1'b0;
   // ==========================================================
   // reset values
   localparam logic [PBCC_ADDR_W-1:0] PBCC_ADDR_RST = 15'h0000;
   localparam logic [PBCC_DATA_W-1:0] PBCC_DATA_RST = 8'h00;
   // ==========================================================
   // sequencer phases, one clock each when not stalled
   typedef enum logic [1:0] {
      PBCC_ST_IDLE,
      PBCC_ST_P0,
      PBCC_ST_P1,
      PBCC_ST_P2
   } pbcc_state_t;
endpackage : pbcc_pkg

// file: hdl/pbcc_fifo.sv
`timescale 1ns/1ps
module pbcc_fifo
   import pbcc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic out_valid_r, out_valid_nxt;
   logic [WIDTH-1:0] out_data_r, out_data_nxt;
   logic push;
   logic pop;

   // ==========================================================
   // next state
   always_comb
   begin
      push = i_in_valid && (cnt_r != FULL_CNT);
      pop = (cnt_r != '0) && (!out_valid_r || i_out_ready);
      wr_ptr_nxt = push ? wr_ptr_r + PTR_ONE : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + PTR_ONE : rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push && !pop)
      begin
         cnt_nxt = cnt_r + CNT_ONE;
      end
      else if (pop && !push)
      begin
         cnt_nxt = cnt_r - CNT_ONE;
      end
      out_data_nxt = pop ? mem_r[rd_ptr_r] : out_data_r;
      out_valid_nxt = pop || (out_valid_r && !i_out_ready);
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
      if (i_srst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r <= cnt_nxt;
         out_valid_r <= out_valid_nxt;
         out_data_r <= out_data_nxt;
      end
   end

   assign o_in_ready = (cnt_r != FULL_CNT);
   assign o_out_valid = out_valid_r;
   assign o_out_data = out_data_r;
endmodule : pbcc_fifo

// file: hdl/pbcc_seq.sv
`timescale 1ns/1ps
module pbcc_seq
   import pbcc_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // instruction command from the core
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_cycles,
   input wire logic i_cmd_bus,
   input wire logic i_cmd_write,
   input wire logic i_cmd_io,
   input wire logic [PBCC_ADDR_W-1:0] i_cmd_addr,
   input wire logic [PBCC_DATA_W-1:0] i_cmd_wdata,
   output logic o_cmd_ready,
   output logic o_instr_done,
   // read data back to the core
   output logic o_rd_valid,
   output logic [PBCC_DATA_W-1:0] o_rd_data,
   input wire logic i_rd_ready,
   // external bus
   output logic [PBCC_ADDR_W-1:0] o_addr,
   output logic o_memory_or_io_select,
   output logic o_read_write_select,
   output logic o_operation_request,
   output logic o_write_strobe_pulse,
   input wire logic i_operation_acknowledge,
   input wire logic [PBCC_DATA_W-1:0] i_dbus,
   output logic [PBCC_DATA_W-1:0] o_dbus,
   output logic o_dbus_oe
);
   // clamps the instruction length to the legal range
   function automatic logic [2:0] pbcc_clamp_cyc(input logic [2:0] c);
      logic [2:0] r;
      r = c;
      if (c < PBCC_MIN_CYC)
      begin
         r = PBCC_MIN_CYC;
      end
      else if (c > PBCC_MAX_CYC)
      begin
         r = PBCC_MAX_CYC;
      end
      return r;
   endfunction : pbcc_clamp_cyc

   pbcc_state_t state_r, state_nxt;
   logic [2:0] cyc_left_r, cyc_left_nxt;
   logic bus_r, bus_nxt;
   logic cmd_ready_r, cmd_ready_nxt;
   logic done_r, done_nxt;
   logic [PBCC_ADDR_W-1:0] addr_r, addr_nxt;
   logic mio_r, mio_nxt;
   logic rw_r, rw_nxt;
   logic req_r, req_nxt;
   logic wsp_r, wsp_nxt;
   logic [PBCC_DATA_W-1:0] dout_r, dout_nxt;
   logic oe_r, oe_nxt;
   logic push;
   logic fifo_in_ready;
   logic accept;

   // ==========================================================
   // read data buffer
   pbcc_fifo #(
      .WIDTH(PBCC_DATA_W),
      .DEPTH(PBCC_FIFO_DEPTH)
   ) u_rd_fifo (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_in_valid(push),
      .i_in_data(i_dbus),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_rd_valid),
      .o_out_data(o_rd_data),
      .i_out_ready(i_rd_ready)
   );

   // ==========================================================
   // sequencer next state
   // all state is held in edge flops with no timers, so the clock may
   // stop or be stepped anywhere in a cycle
   always_comb
   begin
      state_nxt = state_r;
      cyc_left_nxt = cyc_left_r;
      bus_nxt = bus_r;
      done_nxt = 1'b0;
      addr_nxt = addr_r;
      mio_nxt = mio_r;
      rw_nxt = rw_r;
      req_nxt = req_r;
      wsp_nxt = 1'b0;
      dout_nxt = dout_r;
      oe_nxt = oe_r;
      push = 1'b0;
      accept = i_cmd_valid && cmd_ready_r;
      case (state_r)
         PBCC_ST_IDLE:
         begin
            if (accept)
            begin
               // address and controls set one phase ahead of the request
               cyc_left_nxt = pbcc_clamp_cyc(i_cmd_cycles) - PBCC_CYC_STEP;
               bus_nxt = i_cmd_bus;
               addr_nxt = i_cmd_addr;
               mio_nxt = i_cmd_io ? PBCC_SEL_IO : PBCC_SEL_MEM;
               rw_nxt = i_cmd_write ? PBCC_SEL_WRITE : PBCC_SEL_READ;
               dout_nxt = i_cmd_wdata;
               oe_nxt = i_cmd_bus && i_cmd_write;
               state_nxt = PBCC_ST_P0;
            end
         end
         PBCC_ST_P0:
         begin
            // previous acknowledge must be withdrawn before a new request
            if (!(bus_r && i_operation_acknowledge))
            begin
               state_nxt = PBCC_ST_P1;
               req_nxt = bus_r;
               wsp_nxt = bus_r && (rw_r == PBCC_SEL_WRITE);
            end
         end
         PBCC_ST_P1:
         begin
            if (!bus_r)
            begin
               state_nxt = PBCC_ST_P2;
            end
            else if (i_operation_acknowledge)
            begin
               // request falls only on acknowledge
               req_nxt = 1'b0;
               push = (rw_r == PBCC_SEL_READ);
               state_nxt = PBCC_ST_P2;
            end
            // otherwise hold here with the request up
         end
         PBCC_ST_P2:
         begin
            // third clock closes the processor cycle
            bus_nxt = 1'b0;
            oe_nxt = 1'b0;
            if (cyc_left_r == '0)
            begin
               done_nxt = 1'b1;
               state_nxt = PBCC_ST_IDLE;
            end
            else
            begin
               cyc_left_nxt = cyc_left_r - PBCC_CYC_STEP;
               state_nxt = PBCC_ST_P0;
            end
         end
         default:
         begin
            state_nxt = PBCC_ST_IDLE;
         end
      endcase
      // a read is only started when the buffer has room for its byte
      cmd_ready_nxt = (state_nxt == PBCC_ST_IDLE) && fifo_in_ready && !accept;
   end

   // ==========================================================
   // sequencer registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         state_r <= PBCC_ST_IDLE;
         cyc_left_r <= '0;
         bus_r <= 1'b0;
         cmd_ready_r <= 1'b0;
         done_r <= 1'b0;
         addr_r <= PBCC_ADDR_RST;
         mio_r <= PBCC_SEL_MEM;
         rw_r <= PBCC_SEL_READ;
         req_r <= 1'b0;
         wsp_r <= 1'b0;
         dout_r <= PBCC_DATA_RST;
         oe_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cyc_left_r <= cyc_left_nxt;
         bus_r <= bus_nxt;
         cmd_ready_r <= cmd_ready_nxt;
         done_r <= done_nxt;
         addr_r <= addr_nxt;
         mio_r <= mio_nxt;
         rw_r <= rw_nxt;
         req_r <= req_nxt;
         wsp_r <= wsp_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign o_cmd_ready = cmd_ready_r;
   assign o_instr_done = done_r;
   assign o_addr = addr_r;
   assign o_memory_or_io_select = mio_r;
   assign o_read_write_select = rw_r;
   assign o_operation_request = req_r;
   assign o_write_strobe_pulse = wsp_r;
   assign o_dbus = dout_r;
   assign o_dbus_oe = oe_r;
endmodule : pbcc_seq

// file: testbench/pbcc_seq_asserts.sv
`timescale 1ns/1ps
module pbcc_seq_asserts
   import pbcc_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // command side
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_cycles,
   input wire logic i_cmd_bus,
   input wire logic o_cmd_ready,
   input wire logic o_instr_done,
   // bus side
   input wire logic [PBCC_ADDR_W-1:0] o_addr,
   input wire logic o_memory_or_io_select,
   input wire logic o_read_write_select,
   input wire logic o_operation_request,
   input wire logic o_write_strobe_pulse,
   input wire logic o_dbus_oe,
   input wire logic i_operation_acknowledge
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   wire req = o_operation_request;
   wire ack = i_operation_acknowledge;
   wire wp = o_write_strobe_pulse;
   wire rw = o_read_write_select;
   wire [PBCC_ADDR_W+1:0] sel = {o_addr, o_memory_or_io_select, rw};
   wire take = i_cmd_valid && o_cmd_ready && !i_cmd_bus;
   // ==========================================================
   // handshake
   property p_hold; req && !ack |=> req; endproperty
   a_hold: assert property (p_hold) else $error("request dropped early");
   property p_drop; req && ack |=> !req; endproperty
   a_drop: assert property (p_drop) else $error("request kept after ack");
   property p_valid; req && $past(req) |-> $stable(sel); endproperty
   a_valid: assert property (p_valid) else $error("bus changed in request");
   property p_setup; $rose(req) |-> $stable(sel); endproperty
   a_setup: assert property (p_setup) else $error("bus late at request");
   // ==========================================================
   // write strobe
   property p_wp_pos; wp |-> rw && $rose(req); endproperty
   a_wp_pos: assert property (p_wp_pos) else $error("strobe misplaced");
   property p_wp_one; wp |=> !wp; endproperty
   a_wp_one: assert property (p_wp_one) else $error("strobe too long");
   property p_wp_wr; $rose(req) && rw |-> wp; endproperty
   a_wp_wr: assert property (p_wp_wr) else $error("write lacks strobe");
   property p_oe; req |-> (o_dbus_oe == rw); endproperty
   a_oe: assert property (p_oe) else $error("data drive wrong in request");
   // ==========================================================
   // cycle length
   property p_cyc2; take && i_cmd_cycles == 3'h2 |-> ##1 !o_instr_done [*6] ##1 o_instr_done;
   endproperty
   a_cyc2: assert property (p_cyc2) else $error("two cycles wrong");
   property p_cyc4; take && i_cmd_cycles == 3'h4 |-> ##13 o_instr_done; endproperty
   a_cyc4: assert property (p_cyc4) else $error("four cycles wrong");
   c_wr: cover property (wp);
   c_stall: cover property ((req && !ack) [*4]);
   c_done: cover property (o_instr_done);
endmodule : pbcc_seq_asserts

bind pbcc_seq pbcc_seq_asserts u_chk (
   .i_ref_clk(i_ref_clk),
   .i_srst(i_srst),
   .i_cmd_valid(i_cmd_valid),
   .i_cmd_cycles(i_cmd_cycles),
   .i_cmd_bus(i_cmd_bus),
   .o_cmd_ready(o_cmd_ready),
   .o_instr_done(o_instr_done),
   .o_addr(o_addr),
   .o_memory_or_io_select(o_memory_or_io_select),
   .o_read_write_select(o_read_write_select),
   .o_operation_request(o_operation_request),
   .o_write_strobe_pulse(o_write_strobe_pulse),
   .o_dbus_oe(o_dbus_oe),
   .i_operation_acknowledge(i_operation_acknowledge)
);

// file: testbench/pbcc_mem_model.sv
`timescale 1ns/1ps
module pbcc_mem_model
   import pbcc_pkg::*;
(
   // clock
   input wire logic i_ref_clk,
   // bus from the sequencer, answer delay from the bench
   input wire logic i_req,
   input wire logic i_rw,
   input wire logic i_mio,
   input wire logic [PBCC_ADDR_W-1:0] i_addr,
   input wire logic [PBCC_DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_delay,
   // answer
   output logic o_ack = 1'b0,
   output logic [PBCC_DATA_W-1:0] o_rdata = 8'h00,
   output logic [PBCC_ADDR_W+PBCC_DATA_W:0] o_wr_log = '0
);
   logic [3:0] wait_r = 4'h0;
   always @(posedge i_ref_clk)
   begin
      if (i_req && !o_ack)
      begin
         wait_r <= wait_r + 4'h1;
         if (wait_r >= i_delay)
         begin
            o_ack <= 1'b1;
            o_rdata <= i_addr[7:0] ^ (i_mio ? 8'hC3 : 8'h5A);
            if (i_rw)
               o_wr_log <= {i_mio, i_addr, i_wdata};
         end
      end
      else if (!i_req)
      begin
         wait_r <= 4'h0;
         o_ack <= 1'b0;
         // released data lines wander
         o_rdata <= ~o_rdata;
      end
   end
endmodule : pbcc_mem_model

// file: testbench/pbcc_seq_bench.sv
`timescale 1ns/1ps
module pbcc_seq_bench;
   import pbcc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_cmd_valid = 1'b0;
   logic [2:0] i_cmd_cycles = 3'h2;
   logic i_cmd_bus = 1'b0, i_cmd_write = 1'b0, i_cmd_io = 1'b0, i_rd_ready = 1'b0;
   logic [PBCC_ADDR_W-1:0] i_cmd_addr = '0, o_addr;
   logic [PBCC_DATA_W-1:0] i_cmd_wdata = '0, o_rd_data, i_dbus, o_dbus;
   logic o_cmd_ready, o_instr_done, o_rd_valid, o_memory_or_io_select, o_read_write_select;
   logic o_operation_request, o_write_strobe_pulse, i_operation_acknowledge, o_dbus_oe;
   logic [3:0] dly = 4'h0;
   logic hold = 1'b0;
   logic [PBCC_ADDR_W+PBCC_DATA_W:0] wr_log;
   logic [PBCC_DATA_W-1:0] exp_q[$];
   int n_mismatch = 0;
   int n_tests = 0;
   int acc;
   logic tk;
   always #25 i_ref_clk = ~i_ref_clk;
   pbcc_seq dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid),
      .i_cmd_cycles(i_cmd_cycles), .i_cmd_bus(i_cmd_bus), .i_cmd_write(i_cmd_write),
      .i_cmd_io(i_cmd_io), .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata),
      .o_cmd_ready(o_cmd_ready), .o_instr_done(o_instr_done), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_addr(o_addr),
      .o_memory_or_io_select(o_memory_or_io_select), .o_read_write_select(o_read_write_select),
      .o_operation_request(o_operation_request), .o_write_strobe_pulse(o_write_strobe_pulse),
      .i_operation_acknowledge(i_operation_acknowledge), .i_dbus(i_dbus), .o_dbus(o_dbus),
      .o_dbus_oe(o_dbus_oe));
   pbcc_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_req(o_operation_request),
      .i_rw(o_read_write_select), .i_mio(o_memory_or_io_select), .i_addr(o_addr),
      .i_wdata(o_dbus), .i_delay(dly), .o_ack(i_operation_acknowledge),
      .o_rdata(i_dbus), .o_wr_log(wr_log));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask : check
   task print_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   function automatic int clamp(input logic [2:0] c);
      return (c < 3'h2) ? 2 : (c > 3'h4) ? 4 : int'(c);
   endfunction : clamp
   // one command: offered until taken or lim clocks, then timed to done
   task run(input logic [2:0] c, input logic b, input logic w, input logic i, input int lim);
      int n;
      @(negedge i_ref_clk);
      {i_cmd_cycles, i_cmd_bus, i_cmd_write, i_cmd_io} = {c, b, w, i};
      i_cmd_addr = PBCC_ADDR_W'($urandom);
      i_cmd_wdata = PBCC_DATA_W'($urandom);
      i_cmd_valid = 1'b1;
      for (n = 0; n < lim && o_cmd_ready !== 1'b1; n++)
         @(negedge i_ref_clk);
      tk = (o_cmd_ready === 1'b1);
      @(negedge i_ref_clk);
      i_cmd_valid = 1'b0;
      if (!tk)
         return;
      if (b && !w)
         exp_q.push_back(i_cmd_addr[7:0] ^ (i ? 8'h5A : 8'hC3));
      for (n = 0; n < 300 && o_instr_done !== 1'b1; n++)
         @(negedge i_ref_clk);
      if (!b)
         check(n, 3 * clamp(c));
      else
         check(n, 3 * clamp(c) + 1 + int'(dly));
      if (b && w)
         check(wr_log, {!i, i_cmd_addr, i_cmd_wdata});
   endtask : run
   always @(negedge i_ref_clk)
      i_rd_ready <= hold ? 1'b0 : 1'($urandom_range(0, 1));
   always @(posedge i_ref_clk)
      if (!i_srst && o_rd_valid && i_rd_ready)
         check(o_rd_data, exp_q.pop_front());
   task drain;
      for (int t = 0; t < 400 && exp_q.size() > 0; t++)
         @(negedge i_ref_clk);
      check(exp_q.size(), 0);
   endtask : drain
   initial
   begin
      void'($urandom(97059));
      repeat (2) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_srst = 1'b0;
      for (int c = 0; c < 8; c++)
         run(3'(c), 1'b0, 1'b0, 1'b0, 20);
      // all direction and space combinations, prompt then slow
      for (int m = 0; m < 8; m++)
      begin
         dly = m[2] ? 4'hA : 4'h0;
         run(3'h2, 1'b1, m[0], m[1], 20);
      end
      for (int k = 0; k < 50; k++)
      begin
         dly = 4'($urandom_range(0, 5));
         run(3'($urandom_range(0, 7)), 1'($urandom), 1'($urandom), 1'($urandom), 20);
      end
      drain();
      // fill the read buffer until refused, then empty it
      hold = 1'b1;
      dly = 4'h0;
      acc = 0;
      tk = 1'b1;
      while (tk && acc < 40)
      begin
         run(3'h2, 1'b1, 1'b0, 1'($urandom), 40);
         acc += int'(tk);
      end
      check(acc >= PBCC_FIFO_DEPTH && acc <= PBCC_FIFO_DEPTH + 2, 1);
      hold = 1'b0;
      drain();
      print_verdict();
   end
   initial
   begin
      #(50 * 40000);
      n_mismatch++;
      print_verdict();
   end
endmodule : pbcc_seq_bench
